// >>> dmc_chan_ctr.v
// Purpose: Base/current address and word count for one channel
// Assumes: Byte loads, low byte first, selected by i_hi
// Notes:   Writing a base byte also writes the current register
`timescale 1ns/1ps
`include "dmc_defines.vh"

module dmc_chan_ctr (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  input  wire        i_clr,
  // Register loads
  input  wire        i_ld_addr,
  input  wire        i_ld_cnt,
  input  wire        i_hi,
  input  wire [7:0]  i_data,
  // Transfer stepping
  input  wire        i_step,
  input  wire        i_end,
  input  wire        i_dec,
  input  wire        i_auto,
  output wire [15:0] o_addr,
  output wire [15:0] o_cnt,
  output wire        o_tc
);

  reg [15:0] base_addr_reg;
  reg [15:0] base_cnt_reg;
  reg [15:0] cur_addr_reg;
  reg [15:0] cur_cnt_reg;

  // Terminal count when the count passes zero
  assign o_tc   = i_step && (cur_cnt_reg == `DMC_ZERO16);
  assign o_addr = cur_addr_reg;
  assign o_cnt  = cur_cnt_reg;

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      base_addr_reg <= `DMC_ZERO16;
      base_cnt_reg  <= `DMC_ZERO16;
      cur_addr_reg  <= `DMC_ZERO16;
      cur_cnt_reg   <= `DMC_ZERO16;
    end else if (i_clr) begin
      base_addr_reg <= `DMC_ZERO16;
      base_cnt_reg  <= `DMC_ZERO16;
      cur_addr_reg  <= `DMC_ZERO16;
      cur_cnt_reg   <= `DMC_ZERO16;
    end else if (i_ld_addr) begin
      if (i_hi) begin
        base_addr_reg[15:8] <= i_data;
        cur_addr_reg[15:8]  <= i_data;
      end else begin
        base_addr_reg[7:0] <= i_data;
        cur_addr_reg[7:0]  <= i_data;
      end
    end else if (i_ld_cnt) begin
      if (i_hi) begin
        base_cnt_reg[15:8] <= i_data;
        cur_cnt_reg[15:8]  <= i_data;
      end else begin
        base_cnt_reg[7:0] <= i_data;
        cur_cnt_reg[7:0]  <= i_data;
      end
    end else if ((o_tc || i_end) && i_auto) begin
      // Reload wins over the final step
      cur_addr_reg <= base_addr_reg;
      cur_cnt_reg  <= base_cnt_reg;
    end else if (i_step) begin
      if (i_dec) begin
        cur_addr_reg <= cur_addr_reg - `DMC_ONE16;
      end else begin
        cur_addr_reg <= cur_addr_reg + `DMC_ONE16;
      end
      cur_cnt_reg <= cur_cnt_reg - `DMC_ONE16;
    end
  end

endmodule

// >>> dmc_ctrl.v
// Purpose: Four-channel DMA control: masks, modes, requests, status
// Assumes: One I/O access per strobe cycle; i_xfer_done from bus engine
// Notes:   Bus cycle timing and page registers live outside this block
`timescale 1ns/1ps
`include "dmc_defines.vh"

module dmc_ctrl (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rstn,
  // I/O port access
  input  wire [3:0]  i_io_addr,
  input  wire        i_io_wr,
  input  wire        i_io_rd,
  input  wire [7:0]  i_io_wdata,
  output reg  [7:0]  o_io_rdata,
  // Peripheral side
  input  wire [3:0]  i_hardware_channel_request,
  input  wire [3:0]  i_end_of_process,
  // Transfer engine side
  input  wire        i_xfer_done,
  input  wire        i_src_valid,
  input  wire [7:0]  i_src_byte,
  output reg  [3:0]  o_grant,
  output reg         o_mem_to_io,
  output reg         o_io_to_mem,
  output reg         o_verify,
  output reg  [15:0] o_xfer_addr,
  output reg  [3:0]  o_tc
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [3:0] ch_onehot;
    input [1:0] sel;
    begin
      ch_onehot = 4'h1 << sel;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0]  cmd_reg;
  reg [3:0]  mask_reg;
  reg [3:0]  mask_next;
  reg [3:0]  sw_req_reg;
  reg [3:0]  sw_req_next;
  reg [3:0]  tc_stat_reg;
  reg [3:0]  tc_stat_next;
  reg [5:0]  mode_reg [0:3];
  reg [7:0]  temp_reg;
  reg        bptr_reg;
  reg        state_reg;
  reg        state_next;
  reg [1:0]  cur_ch_reg;
  reg [1:0]  last_ch_reg;
  reg [1:0]  win_ch;
  reg        win_ok;
  reg [1:0]  probe;
  reg        release_now;
  reg [7:0]  rd_next;
  integer    k;
  integer    m;
  integer    j;

  wire        mclr   = i_io_wr && (i_io_addr == `DMC_P_MCLR);
  wire        wr_req = i_io_wr && (i_io_addr == `DMC_P_REQ);
  wire        wr_sm  = i_io_wr && (i_io_addr == `DMC_P_SMASK);
  wire        wr_am  = i_io_wr && (i_io_addr == `DMC_P_ALL_MASK);
  wire        wr_cm  = i_io_wr && (i_io_addr == `DMC_P_CLR_MASK);
  wire        wr_md  = i_io_wr && (i_io_addr == `DMC_P_MODE);
  wire        chan_acc = (i_io_wr || i_io_rd) && (i_io_addr <= `DMC_P_CHAN_HI);
  wire        rd_stat = i_io_rd && (i_io_addr == `DMC_P_CMD_STAT);
  wire [3:0]  pend;
  wire [3:0]  step;
  wire [3:0]  ch_tc;
  wire [3:0]  ch_end;
  wire [63:0] addr_bus;
  wire [63:0] cnt_bus;
  wire [5:0]  cur_mode = mode_reg[cur_ch_reg];
  wire        busy     = (state_reg == `DMC_ST_BUSY);
  wire        cascade  = (cur_mode[`DMC_M_OP] == `DMC_OP_CASCADE);

  // Masked hardware lines drop out; software flags always pass
  assign pend = (i_hardware_channel_request & ~mask_reg) | sw_req_reg;

  // ----------------------------------------------------------------
  // Per-channel counters
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      // Cascade passes the bus through without stepping
      assign step[g] = busy && i_xfer_done && (cur_ch_reg == g) &&
                       (mode_reg[g][`DMC_M_OP] != `DMC_OP_CASCADE);
      assign ch_end[g] = ch_tc[g] || i_end_of_process[g];
      dmc_chan_ctr u_ctr (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_clr     (mclr),
        .i_ld_addr (chan_acc && i_io_wr && (i_io_addr == 2 * g)),
        .i_ld_cnt  (chan_acc && i_io_wr && (i_io_addr == 2 * g + 1)),
        .i_hi      (bptr_reg),
        .i_data    (i_io_wdata),
        .i_step    (step[g]),
        .i_end     (i_end_of_process[g]),
        .i_dec     (mode_reg[g][`DMC_M_DEC]),
        .i_auto    (mode_reg[g][`DMC_M_AUTO]),
        .o_addr    (addr_bus[16*g +: 16]),
        .o_cnt     (cnt_bus[16*g +: 16]),
        .o_tc      (ch_tc[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Rotating priority starts just after the last serviced channel
  always @* begin
    win_ch = 2'h0;
    win_ok = 1'b0;
    probe  = 2'h0;
    for (k = 3; k >= 0; k = k - 1) begin
      probe = (cmd_reg[`DMC_CMD_ROT] ? last_ch_reg + 2'h1 : 2'h0) + k[1:0];
      if (pend[probe]) begin
        win_ch = probe;
        win_ok = 1'b1;
      end
    end
  end

  // Mode decides how long a channel keeps the bus
  always @* begin
    release_now = 1'b0;
    case (cur_mode[`DMC_M_OP])
      `DMC_OP_SINGLE: release_now = i_xfer_done || ch_end[cur_ch_reg];
      `DMC_OP_BLOCK: release_now = ch_end[cur_ch_reg];
      `DMC_OP_DEMAND: release_now = ch_end[cur_ch_reg] || !pend[cur_ch_reg];
      `DMC_OP_CASCADE: release_now = !pend[cur_ch_reg];
      default: release_now = 1'b1;
    endcase
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `DMC_ST_IDLE: begin
        if (win_ok && cmd_reg[`DMC_CMD_EN]) begin
          state_next = `DMC_ST_BUSY;
        end
      end
      `DMC_ST_BUSY: begin
        if (release_now || !cmd_reg[`DMC_CMD_EN]) begin
          state_next = `DMC_ST_IDLE;
        end
      end
      default: state_next = `DMC_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Masks, software requests, status flags
  // ----------------------------------------------------------------
  always @* begin
    mask_next    = mask_reg;
    sw_req_next  = sw_req_reg;
    tc_stat_next = tc_stat_reg;
    if (wr_sm) begin
      if (i_io_wdata[`DMC_SETBIT]) begin
        mask_next = mask_reg | ch_onehot(i_io_wdata[`DMC_SEL]);
      end else begin
        mask_next = mask_reg & ~ch_onehot(i_io_wdata[`DMC_SEL]);
      end
    end else if (wr_am) begin
      mask_next = i_io_wdata[`DMC_MASKS];
    end else if (wr_cm) begin
      mask_next = `DMC_ZERO4;
    end
    if (wr_req) begin
      if (i_io_wdata[`DMC_SETBIT]) begin
        sw_req_next = sw_req_reg | ch_onehot(i_io_wdata[`DMC_SEL]);
      end else begin
        sw_req_next = sw_req_reg & ~ch_onehot(i_io_wdata[`DMC_SEL]);
      end
    end
    // Status read clears; a new end in the same cycle still sets
    if (rd_stat) begin
      tc_stat_next = `DMC_ZERO4;
    end
    for (m = 0; m < 4; m = m + 1) begin
      if (ch_end[m]) begin
        tc_stat_next[m] = 1'b1;
        sw_req_next[m]  = 1'b0;
        if (!mode_reg[m][`DMC_M_AUTO]) begin
          mask_next[m] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    rd_next = o_io_rdata;
    if (i_io_rd) begin
      case (i_io_addr)
        `DMC_P_CMD_STAT: rd_next = {pend, tc_stat_reg};
        `DMC_P_TEMP_BPTR: rd_next = temp_reg;
        default: begin
          if (i_io_addr <= `DMC_P_CHAN_HI) begin
            if (i_io_addr[0]) begin
              rd_next = bptr_reg ? cnt_bus[16*i_io_addr[2:1] + 8 +: 8]
                                 : cnt_bus[16*i_io_addr[2:1] +: 8];
            end else begin
              rd_next = bptr_reg ? addr_bus[16*i_io_addr[2:1] + 8 +: 8]
                                 : addr_bus[16*i_io_addr[2:1] +: 8];
            end
          end else begin
            rd_next = `DMC_ZERO8;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cmd_reg     <= `DMC_ZERO8;
      temp_reg    <= `DMC_ZERO8;
      mask_reg    <= `DMC_ALL4;
      sw_req_reg  <= `DMC_ZERO4;
      tc_stat_reg <= `DMC_ZERO4;
      bptr_reg    <= 1'b0;
      o_io_rdata  <= `DMC_ZERO8;
    end else begin
      o_io_rdata <= rd_next;
      if (mclr) begin
        cmd_reg     <= `DMC_ZERO8;
        temp_reg    <= `DMC_ZERO8;
        mask_reg    <= `DMC_ALL4;
        sw_req_reg  <= `DMC_ZERO4;
        tc_stat_reg <= `DMC_ZERO4;
        bptr_reg    <= 1'b0;
      end else begin
        mask_reg    <= mask_next;
        sw_req_reg  <= sw_req_next;
        tc_stat_reg <= tc_stat_next;
        if (i_io_wr && (i_io_addr == `DMC_P_CMD_STAT)) begin
          cmd_reg <= i_io_wdata;
        end
        if (i_io_wr && (i_io_addr == `DMC_P_TEMP_BPTR)) begin
          bptr_reg <= 1'b0;
        end else if (chan_acc) begin
          bptr_reg <= ~bptr_reg;
        end
        // Only meaningful while memory-to-memory is enabled
        if (i_src_valid && cmd_reg[`DMC_CMD_M2M]) begin
          temp_reg <= i_src_byte;
        end
      end
    end
  end

  // Mode store in one process so the array has a single driver
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (j = 0; j < 4; j = j + 1) begin
        mode_reg[j] <= `DMC_ZERO6;
      end
    end else if (wr_md) begin
      mode_reg[i_io_wdata[`DMC_SEL]] <= i_io_wdata[`DMC_MODE_FIELD];
    end
  end

  // ----------------------------------------------------------------
  // Grant and transfer outputs
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg   <= `DMC_ST_IDLE;
      cur_ch_reg  <= 2'h0;
      last_ch_reg <= 2'h3;
      o_grant     <= `DMC_ZERO4;
      o_mem_to_io <= 1'b0;
      o_io_to_mem <= 1'b0;
      o_verify    <= 1'b0;
      o_xfer_addr <= `DMC_ZERO16;
      o_tc        <= `DMC_ZERO4;
    end else if (mclr) begin
      state_reg   <= `DMC_ST_IDLE;
      last_ch_reg <= 2'h3;
      o_grant     <= `DMC_ZERO4;
      o_mem_to_io <= 1'b0;
      o_io_to_mem <= 1'b0;
      o_verify    <= 1'b0;
      o_tc        <= `DMC_ZERO4;
    end else begin
      state_reg <= state_next;
      o_tc      <= ch_tc;
      if (state_reg == `DMC_ST_IDLE && state_next == `DMC_ST_BUSY) begin
        cur_ch_reg <= win_ch;
        o_grant    <= ch_onehot(win_ch);
      end else if (state_next == `DMC_ST_IDLE) begin
        if (busy) begin
          last_ch_reg <= cur_ch_reg;
        end
        o_grant <= `DMC_ZERO4;
      end
      o_xfer_addr <= addr_bus[16*cur_ch_reg +: 16];
      if (busy && !cascade) begin
        o_mem_to_io <= (cur_mode[`DMC_M_TYPE] == `DMC_TT_READ);
        o_io_to_mem <= (cur_mode[`DMC_M_TYPE] == `DMC_TT_WRITE);
        o_verify    <= (cur_mode[`DMC_M_TYPE] == `DMC_TT_VERIFY);
      end else begin
        // Cascade leaves transfer type unused
        o_mem_to_io <= 1'b0;
        o_io_to_mem <= 1'b0;
        o_verify    <= 1'b0;
      end
    end
  end

endmodule

// >>> dmc_ctrl_monitor.sv
// Purpose: Port-level checker for dmc_ctrl
// Assumes: Sees only the top ports, one clock domain
// Notes:   Bind follows the module
`timescale 1ns/1ps
module dmc_ctrl_monitor (
  // Clock and reset
  input wire       i_sys_clk,
  input wire       i_rstn,
  // Observed ports
  input wire [3:0] i_io_addr,
  input wire       i_io_wr,
  input wire       i_io_rd,
  input wire [7:0] i_io_wdata,
  input wire [7:0] o_io_rdata,
  input wire [3:0] i_end_of_process,
  input wire       i_xfer_done,
  input wire [3:0] o_grant,
  input wire       o_mem_to_io,
  input wire       o_io_to_mem,
  input wire       o_verify,
  input wire [3:0] o_tc
);
  // ----------------------------------------
  // Enable shadow
  // ----------------------------------------
  reg en_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn)
      en_reg <= 1'b0;
    else if (i_io_wr && i_io_addr == 4'h8)
      en_reg <= i_io_wdata[2];
    else if (i_io_wr && i_io_addr == 4'hD)
      en_reg <= 1'b0;
  end
  default clocking mon_cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  grant_onehot_a: assert property ($onehot0(o_grant))
    else $error("grant not one-hot");
  type_onehot_a: assert property ($onehot0({o_mem_to_io, o_io_to_mem, o_verify}))
    else $error("more than one transfer type");
  idle_type_a: assert property (o_grant == 4'h0 && $past(o_grant) == 4'h0
    |-> {o_mem_to_io, o_io_to_mem, o_verify} == 3'h0) else $error("type while idle");
  off_no_grant_a: assert property (!en_reg && !$past(en_reg) |-> o_grant == 4'h0)
    else $error("grant while disabled");
  tc_single_a: assert property ((o_tc & $past(o_tc)) == 4'h0)
    else $error("terminal count longer than a pulse");
  tc_cause_a: assert property (o_tc != 4'h0
    |-> $past(i_xfer_done) && o_tc == $past(o_grant)) else $error("stray terminal count");
  rdata_hold_a: assert property (!i_io_rd && !(i_io_wr && i_io_addr == 4'hD)
    |=> $stable(o_io_rdata)) else $error("read data moved");
  eop_status_a: assert property ($past(i_end_of_process) != 4'h0 && i_io_rd
    && i_io_addr == 4'h8 |=> (o_io_rdata[3:0] & $past(i_end_of_process, 2))
    == $past(i_end_of_process, 2)) else $error("end flag missing");
  mclr_drop_a: assert property (i_io_wr && i_io_addr == 4'hD
    |-> ##2 (o_grant == 4'h0) [*3]) else $error("grant after master clear");
endmodule

bind dmc_ctrl dmc_ctrl_monitor u_mon (.i_sys_clk, .i_rstn, .i_io_addr, .i_io_wr, .i_io_rd,
  .i_io_wdata, .o_io_rdata, .i_end_of_process, .i_xfer_done, .o_grant, .o_mem_to_io,
  .o_io_to_mem, .o_verify, .o_tc);

// >>> dmc_ctrl_tb.sv
// Purpose: Self-checking bench for dmc_ctrl
// Assumes: 40 MHz clock, reset held 4 cycles
// Notes:   Random fields from a fixed-seed shift register
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module dmc_ctrl_tb;
  reg         i_sys_clk = 1'b0;
  reg         i_rstn = 1'b0;
  reg  [3:0]  i_io_addr = 4'h0;
  reg         i_io_wr = 1'b0;
  reg         i_io_rd = 1'b0;
  reg  [7:0]  i_io_wdata = 8'h00;
  reg  [3:0]  i_hardware_channel_request = 4'h0;
  reg  [3:0]  i_end_of_process = 4'h0;
  reg  [3:0]  m_delay = 4'h4;
  reg         m_quiet = 1'b0;
  reg  [7:0]  m_byte = 8'h00;
  wire [7:0]  o_io_rdata, src_byte;
  wire [3:0]  o_grant, o_tc;
  wire        o_mem_to_io, o_io_to_mem, o_verify, xfer_done, src_valid;
  wire [15:0] o_xfer_addr;
  int         errors = 0;
  int         comparisons = 0;
  int         i;
  reg  [31:0] seed;
  reg  [15:0] base;
  reg  [7:0]  lo, hi, st;
  reg  [1:0]  ch, tt, op;
  reg         dec, auto_en;
  always #12.5 i_sys_clk = ~i_sys_clk;
  dmc_ctrl DUT (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .i_hardware_channel_request(i_hardware_channel_request),
    .i_end_of_process(i_end_of_process), .i_xfer_done(xfer_done), .i_src_valid(src_valid),
    .i_src_byte(src_byte), .o_grant(o_grant), .o_mem_to_io(o_mem_to_io),
    .o_io_to_mem(o_io_to_mem), .o_verify(o_verify), .o_xfer_addr(o_xfer_addr), .o_tc(o_tc));
  dmc_xfer_model u_model (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_grant(o_grant),
    .i_delay(m_delay), .i_quiet(m_quiet), .i_byte(m_byte), .o_done(xfer_done),
    .o_src_valid(src_valid), .o_src_byte(src_byte));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [2:0] type_exp(input [1:0] t);
    case (t)
      2'h0: type_exp = 3'h1;
      2'h1: type_exp = 3'h2;
      2'h2: type_exp = 3'h4;
      default: type_exp = 3'h0;
    endcase
  endfunction
  function [15:0] addr_exp(input [15:0] b, input d, input a);
    if (a) addr_exp = b;
    else if (d) addr_exp = b - 16'h0001;
    else addr_exp = b + 16'h0001;
  endfunction
  task automatic io_wr(input [3:0] a, input [7:0] d);
    @(posedge i_sys_clk);
    i_io_addr  <= a;
    i_io_wdata <= d;
    i_io_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_io_wr    <= 1'b0;
  endtask
  task automatic io_rd(input [3:0] a, output [7:0] d);
    @(posedge i_sys_clk);
    i_io_addr <= a;
    i_io_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_io_rd   <= 1'b0;
    #1 d = o_io_rdata;
  endtask
  task automatic rd_chk(input [3:0] a, input [7:0] e);
    reg [7:0] v;
    io_rd(a, v);
    `CHK(v, e)
  endtask
  task automatic drive_hw(input [3:0] v);
    @(posedge i_sys_clk);
    i_hardware_channel_request <= v;
  endtask
  // Bounded waits: a stuck grant must not hang the run
  task automatic wait_grant(input [3:0] e);
    int n;
    n = 0;
    while (o_grant === 4'h0 && n < 40) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    `CHK(o_grant, e)
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (o_grant !== 4'h0 && n < 40) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    `CHK(o_grant, 4'h0)
  endtask
  task automatic no_grant;
    repeat (8) @(posedge i_sys_clk);
    #1 `CHK(o_grant, 4'h0)
  endtask
  // End pulse, then a status read on the very next cycle
  task automatic eop_rd(input [1:0] c, output [7:0] d);
    @(posedge i_sys_clk);
    i_end_of_process <= 4'h1 << c;
    @(posedge i_sys_clk);
    i_end_of_process <= 4'h0;
    i_hardware_channel_request <= 4'h0;
    i_io_addr <= 4'h8;
    i_io_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_io_rd <= 1'b0;
    #1 d = o_io_rdata;
  endtask
  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #(25 * 10000);
    errors++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    rd_chk(4'h8, 8'h00);
    rd_chk(4'hC, 8'h00);
    io_wr(4'hF, 8'h5A);
    drive_hw(4'hF);
    repeat (2) @(posedge i_sys_clk);
    rd_chk(4'h8, 8'h50);
    drive_hw(4'h0);
    io_wr(4'hF, 8'h0F);
    io_wr(4'h9, 8'h06);
    rd_chk(4'h8, 8'h40);
    io_wr(4'h8, 8'h04);
    wait_grant(4'h4);
    wait_idle;
    rd_chk(4'h8, 8'h04);
    seed = 32'h0000_2f0f;
    for (i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      ch = i[1:0];
      tt = 2'(i % 3);
      op = 2'(i / 4);
      base = seed[15:0];
      dec = seed[16];
      auto_en = seed[17];
      m_delay <= seed[23:20] | 4'h4;
      m_byte <= seed[31:24];
      io_wr(4'hF, {seed[27:24], 4'h0});
      io_wr(4'hC, 8'h00);
      io_wr({1'b0, ch, 1'b0}, base[7:0]);
      io_wr({1'b0, ch, 1'b0}, base[15:8]);
      io_wr({1'b0, ch, 1'b1}, 8'h00);
      io_wr({1'b0, ch, 1'b1}, 8'h00);
      io_wr(4'hB, {op, dec, auto_en, tt, ch});
      io_wr(4'h9, {5'h00, 1'b1, ch});
      io_wr(4'h8, (i == 0) ? 8'h05 : 8'h04);
      wait_grant(4'h1 << ch);
      @(posedge i_sys_clk);
      #1 `CHK({o_mem_to_io, o_io_to_mem, o_verify}, type_exp(tt))
      `CHK(o_xfer_addr, base)
      wait_idle;
      rd_chk(4'h8, 8'h01 << ch);
      if (i == 0) rd_chk(4'hC, seed[31:24]);
      io_wr(4'hC, 8'h00);
      io_rd({1'b0, ch, 1'b0}, lo);
      io_rd({1'b0, ch, 1'b0}, hi);
      `CHK({hi, lo}, addr_exp(base, dec, auto_en))
      io_rd({1'b0, ch, 1'b1}, lo);
      io_rd({1'b0, ch, 1'b1}, hi);
      `CHK({hi, lo}, auto_en ? 16'h0000 : 16'hFFFF)
      drive_hw(4'h1 << ch);
      if (!auto_en) begin
        no_grant;
        io_wr(4'hA, {6'h00, ch});
      end
      wait_grant(4'h1 << ch);
      eop_rd(ch, st);
      `CHK(st[3:0], 4'h1 << ch)
      wait_idle;
    end
    io_wr(4'hF, 8'h00);
    m_quiet <= 1'b1;
    io_wr(4'hB, 8'hCB);
    drive_hw(4'h8);
    wait_grant(4'h8);
    @(posedge i_sys_clk);
    #1 `CHK({o_mem_to_io, o_io_to_mem, o_verify}, 3'h0)
    drive_hw(4'h0);
    wait_idle;
    `CHK(o_grant, 4'h0)
    m_quiet <= 1'b0;
    io_wr(4'hD, 8'h00);
    rd_chk(4'hC, 8'h00);
    io_wr(4'h9, 8'h05);
    no_grant;
    rd_chk(4'h8, 8'h20);
    finish_test;
  end
endmodule

// >>> dmc_defines.vh
// Purpose: Constants for the four-channel DMA channel control block
// Assumes: Byte-wide I/O port access on a 4-bit port offset
// Notes:   Included by dmc_ctrl.v and dmc_chan_ctr.v
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH

// ----------------------------------------------------------------
// Port offsets
// ----------------------------------------------------------------
`define DMC_P_CMD_STAT   4'h8
`define DMC_P_REQ        4'h9
`define DMC_P_SMASK      4'hA
`define DMC_P_MODE       4'hB
`define DMC_P_TEMP_BPTR  4'hC
`define DMC_P_MCLR       4'hD
`define DMC_P_CLR_MASK   4'hE
`define DMC_P_ALL_MASK   4'hF
`define DMC_P_CHAN_HI    4'h7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMC_SEL          1:0
`define DMC_SETBIT       2
`define DMC_MODE_OP      7:6
`define DMC_MODE_DEC     5
`define DMC_MODE_AUTO    4
`define DMC_MODE_TYPE    3:2
`define DMC_MODE_FIELD   7:2
`define DMC_M_OP         5:4
`define DMC_M_DEC        3
`define DMC_M_AUTO       2
`define DMC_M_TYPE       1:0
`define DMC_CMD_M2M      0
`define DMC_CMD_EN       2
`define DMC_CMD_ROT      4
`define DMC_MASKS        3:0

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define DMC_OP_DEMAND    2'h0
`define DMC_OP_SINGLE    2'h1
`define DMC_OP_BLOCK     2'h2
`define DMC_OP_CASCADE   2'h3
`define DMC_TT_VERIFY    2'h0
`define DMC_TT_WRITE     2'h1
`define DMC_TT_READ      2'h2
`define DMC_ZERO8        8'h00
`define DMC_ZERO6        6'h00
`define DMC_ZERO4        4'h0
`define DMC_ZERO16       16'h0000
`define DMC_ALL4         4'hF
`define DMC_ONE16        16'h0001
`define DMC_ST_IDLE      1'b0
`define DMC_ST_BUSY      1'b1

`endif

// >>> dmc_xfer_model.sv
// Purpose: Transfer engine stand-in facing the grant outputs
// Assumes: One transfer per grant, after a set delay
// Notes:   Source byte line toggles when not valid
`timescale 1ns/1ps
module dmc_xfer_model (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_rstn,
  // Control from bench and design
  input  wire [3:0] i_grant,
  input  wire [3:0] i_delay,
  input  wire       i_quiet,
  input  wire [7:0] i_byte,
  // Answers
  output reg        o_done,
  output reg        o_src_valid,
  output reg  [7:0] o_src_byte
);
  reg [3:0] wait_reg;
  reg       sent_reg;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_reg    <= 4'h0;
      sent_reg    <= 1'b0;
      o_done      <= 1'b0;
      o_src_valid <= 1'b0;
      o_src_byte  <= 8'h00;
    end else begin
      o_done      <= 1'b0;
      o_src_valid <= 1'b0;
      // No stale byte survives a cycle
      o_src_byte  <= ~o_src_byte;
      if (i_grant == 4'h0) begin
        sent_reg <= 1'b0;
        wait_reg <= i_delay;
      end else if (!sent_reg && !i_quiet) begin
        if (wait_reg == 4'h0) begin
          o_done      <= 1'b1;
          o_src_valid <= 1'b1;
          o_src_byte  <= i_byte;
          sent_reg    <= 1'b1;
        end else
          wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule
